// >>> hw/ptp_ts_pkg.sv
package ptp_ts_pkg;

	// Stream widths
	localparam int DATA_W  = 64;
	localparam int KEEP_W  = 8;
	localparam int CMD_W   = 64;
	localparam int TUSER_W = 128;
	localparam int TS_W    = 80;
	localparam int SEC_W   = 48;
	localparam int NS_W    = 32;
	localparam int LAT_W   = 32;
	localparam int ABS_W   = 16;

	// Command field layout
	localparam int OP_LSB     = 0;
	localparam int CK_BIT     = 8;
	localparam int TAG_LSB    = 16;
	localparam int TAG_W      = 16;
	localparam int OFF_LSB    = 32;
	localparam int CKO_LSB    = 48;
	localparam int OFFSET_W   = 16;

	// Transmit user sideband layout
	localparam int TUSER_UNDERRUN = 0;
	localparam int TUSER_CMD_LSB  = 64;

	// FIFO word layout: {cmd, underrun, sof, last, keep, data}
	localparam int FW_KEEP_LSB = 64;
	localparam int FW_LAST     = 72;
	localparam int FW_SOF      = 73;
	localparam int FW_UNR      = 74;
	localparam int FW_CMD_LSB  = 75;
	localparam int FIFO_W      = 139;
	localparam int FIFO_DEPTH  = 16;

	// Frame editing geometry
	localparam int WIN_BYTES   = 24;
	localparam int BEAT_BYTES  = 8;
	localparam int TOD_BYTES   = 10;
	localparam int CF_BYTES    = 8;
	localparam int CK_BEFORE_CF = 10;
	localparam int TOD_WORDS   = 5;
	localparam int CF_WORDS    = 4;

	// Timing and arithmetic constants
	localparam logic [NS_W-1:0]  NS_PER_SEC  = 32'h3B9ACA00;
	localparam logic [LAT_W-1:0] TX_LAT_RST  = 32'h0000_0080;
	localparam logic [31:0]      CRC_POLY    = 32'hEDB88320;
	localparam logic [31:0]      CRC_INIT    = 32'hFFFFFFFF;

	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_ONE  = 2'b01,
		OP_TWO  = 2'b10,
		OP_RSVD = 2'b11
	} ptp_op_t;

	typedef enum logic [1:0] {
		ST_GAP     = 2'b00,
		ST_CMDHELD = 2'b01,
		ST_FRAME   = 2'b10
	} in_state_t;

endpackage

// >>> hw/beat_if.sv
`timescale 1ns/100ps
`default_nettype none

// One valid/ready word channel
interface beat_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface // beat_if

`default_nettype wire

// >>> hw/beat_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module beat_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Channels
	beat_if.snk       wr,
	beat_if.src       rd
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic [W-1:0]  out_r;
	logic          out_v_r;
	logic          push;
	logic          pop;

	// Ready drops once the array is full, so the source really stalls
	assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
	assign push     = wr.valid && wr.ready;
	assign pop      = (cnt_r != '0) && (!out_v_r || rd.ready);
	assign rd.valid = out_v_r;
	assign rd.data  = out_r;

	// Storage array
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wp_r] <= wr.data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Head word sits in a register so read data come from a flop
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			out_v_r <= 1'b0;
			out_r   <= '0;
		end else if (pop) begin
			out_v_r <= 1'b1;
			out_r   <= mem[rp_r];
		end else if (rd.ready) begin
			out_v_r <= 1'b0;
		end
	end

endmodule // beat_fifo

`default_nettype wire

// >>> hw/ptp_timestamp_command_path.sv
`timescale 1ns/100ps
`default_nettype none

module ptp_timestamp_command_path
	import ptp_ts_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Configuration
	input  wire logic                 inband_cmd_en,
	input  wire logic                 custom_preamble_en,
	input  wire logic                 cf_format_sel,
	input  wire logic                 rx_inline_ts_en,
	input  wire logic                 tx_lat_wr,
	input  wire logic [LAT_W-1:0]     tx_lat_val,
	output logic      [LAT_W-1:0]     tx_lat_cur,
	// System timer
	input  wire logic [TS_W-1:0]      systime,
	// Client transmit stream
	input  wire logic [DATA_W-1:0]    s_axis_tx_tdata,
	input  wire logic [KEEP_W-1:0]    s_axis_tx_tkeep,
	input  wire logic                 s_axis_tx_tlast,
	input  wire logic [TUSER_W-1:0]   s_axis_tx_tuser,
	input  wire logic                 s_axis_tx_tvalid,
	output logic                      s_axis_tx_tready,
	// Line-side transmit stream
	output logic      [DATA_W-1:0]    tx_out_data,
	output logic      [KEEP_W-1:0]    tx_out_keep,
	output logic                      tx_out_last,
	output logic                      tx_out_underrun,
	output logic      [31:0]          tx_out_fcs,
	output logic                      tx_out_valid,
	input  wire logic                 tx_out_ready,
	// Transmit timestamp return
	output logic                      tx_ts_valid,
	output logic      [TS_W-1:0]      tx_ts,
	output logic      [TAG_W-1:0]     tx_ts_tag,
	output logic                      tx_ts_two_step,
	// Receive from coding layer
	input  wire logic                 rx_start,
	input  wire logic [DATA_W-1:0]    rx_in_data,
	input  wire logic [KEEP_W-1:0]    rx_in_keep,
	input  wire logic                 rx_in_last,
	input  wire logic                 rx_in_pre,
	input  wire logic                 rx_in_valid,
	// Client receive stream and timestamp
	output logic      [DATA_W-1:0]    m_axis_rx_tdata,
	output logic      [KEEP_W-1:0]    m_axis_rx_tkeep,
	output logic                      m_axis_rx_tlast,
	output logic                      m_axis_rx_tvalid,
	output logic                      rx_ts_valid,
	output logic      [TS_W-1:0]      rx_ts
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic ptp_op_t cmd_op(input logic [CMD_W-1:0] c);
		return ptp_op_t'(c[OP_LSB +: 2]);
	endfunction

	function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction

	// Latency added in the format's own units; assumes latency below one second
	function automatic logic [TS_W-1:0] ts_adjust(input logic [TS_W-1:0] t, input logic [LAT_W-1:0] lat,
			input logic cf);
		logic [NS_W:0]   ns;
		logic [SEC_W-1:0] sec;
		logic [CMD_W-1:0] cfv;
		ns  = {1'b0, t[NS_W-1:0]} + {1'b0, lat};
		sec = t[TS_W-1:NS_W];
		cfv = t[CMD_W-1:0] + {32'h0000_0000, lat};
		if (ns >= {1'b0, NS_PER_SEC}) begin
			ns  = ns - {1'b0, NS_PER_SEC};
			sec = sec + 1'b1;
		end
		if (cf) begin
			return {16'h0000, cfv};
		end
		return {sec, ns[NS_W-1:0]};
	endfunction

	// Ones complement sum of the five wallclock stamp words
	function automatic logic [15:0] ts_words(input logic [TS_W-1:0] t);
		logic [15:0] s;
		s = 16'h0000;
		for (int k = 0; k < TOD_WORDS; k++) begin
			s = oc_add(s, t[k*16 +: 16]);
		end
		return s;
	endfunction

	function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [DATA_W-1:0] d,
			input logic [KEEP_W-1:0] k);
		logic [31:0] r;
		r = c;
		for (int b = 0; b < KEEP_W; b++) begin
			for (int i = 0; i < 8; i++) begin
				if (k[b]) begin
					r = (r >> 1) ^ ((r[0] ^ d[b*8+i]) ? CRC_POLY : 32'h0000_0000);
				end
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Input stage: command capture ahead of the FIFO

	beat_if #(.W(FIFO_W)) fin ();
	beat_if #(.W(FIFO_W)) fout ();

	in_state_t        in_st_r;
	logic [CMD_W-1:0] cmd_hold_r;
	logic             inband_act;
	logic             cmd_beat;
	logic [CMD_W-1:0] cmd_in;

	assign inband_act = inband_cmd_en && !custom_preamble_en;
	assign cmd_beat   = inband_act && (in_st_r == ST_GAP);
	// Command beat is swallowed here and never reaches the FIFO
	assign s_axis_tx_tready = cmd_beat ? 1'b1 : fin.ready;
	assign fin.valid  = s_axis_tx_tvalid && !cmd_beat;
	assign cmd_in     = inband_act ? cmd_hold_r : s_axis_tx_tuser[TUSER_CMD_LSB +: CMD_W];
	assign fin.data   = {cmd_in, s_axis_tx_tuser[TUSER_UNDERRUN], in_st_r != ST_FRAME,
		s_axis_tx_tlast, s_axis_tx_tkeep, s_axis_tx_tdata};

	// Frame boundary tracking on the client side
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			in_st_r    <= ST_GAP;
			cmd_hold_r <= '0;
		end else if (s_axis_tx_tvalid && s_axis_tx_tready) begin
			if (cmd_beat) begin
				cmd_hold_r <= s_axis_tx_tdata;
				in_st_r    <= ST_CMDHELD;
			end else begin
				in_st_r <= s_axis_tx_tlast ? ST_GAP : ST_FRAME;
			end
		end
	end

	beat_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr       (fin),
		.rd       (fout)
	);

	////////////////////////////////////////////////////////////////////////
	// Edit window: three beats deep so checksum and correction field meet

	logic [DATA_W-1:0] wd_r [0:2];
	logic [KEEP_W-1:0] wk_r [0:2];
	logic [2:0]        wl_r;
	logic [2:0]        ws_r;
	logic [2:0]        wu_r;
	logic [2:0]        wv_r;
	logic              tail_r;
	logic [12:0]       cnt_r;
	logic [CMD_W-1:0]  ctx_cmd_r;
	logic [TS_W-1:0]   ts_r;
	logic [LAT_W-1:0]  tx_lat_r;
	logic [31:0]       crc_r;

	logic [DATA_W-1:0] f_data;
	logic [KEEP_W-1:0] f_keep;
	logic              f_last;
	logic              f_sof;
	logic              f_unr;
	logic [CMD_W-1:0]  f_cmd;
	logic              busy;
	logic              take_in;
	logic              shift;
	logic [CMD_W-1:0]  cur_cmd;
	logic [TS_W-1:0]   ts_now;
	logic [TS_W-1:0]   cur_ts;
	logic [DATA_W-1:0] ed0;
	logic [DATA_W-1:0] ed1;
	logic [DATA_W-1:0] edi;

	assign {f_cmd, f_unr, f_sof, f_last, f_keep, f_data} = fout.data;
	assign busy    = |wv_r;
	// A new frame waits until the previous one has fully drained
	assign take_in = fout.valid && !tail_r && !(f_sof && busy);
	assign shift   = (!wv_r[2] || tx_out_ready) && (take_in || tail_r);
	assign fout.ready = shift && take_in;
	assign cur_cmd = f_sof ? f_cmd : ctx_cmd_r;
	assign ts_now  = ts_adjust(systime, tx_lat_r, cf_format_sel);
	assign cur_ts  = f_sof ? ts_now : ts_r;

	// Byte edits applied on the incoming beat and the two beats behind it
	always_comb begin
		logic [7:0]       vb [0:WIN_BYTES-1];
		logic [15:0]      ck;
		logic [CMD_W-1:0] old_cf;
		logic [CMD_W-1:0] new_cf;
		int               in_abs;
		int               off;
		int               cko;
		int               a;
		int               base;
		logic             one;
		a = 0;
		for (int i = 0; i < BEAT_BYTES; i++) begin
			vb[i]              = wd_r[1][i*8 +: 8];
			vb[i+BEAT_BYTES]   = wd_r[0][i*8 +: 8];
			vb[i+2*BEAT_BYTES] = f_data[i*8 +: 8];
		end
		ck     = 16'h0000;
		old_cf = '0;
		new_cf = '0;
		in_abs = f_sof ? 0 : int'(cnt_r) * BEAT_BYTES;
		off    = int'(cur_cmd[OFF_LSB +: OFFSET_W]);
		cko    = int'(cur_cmd[CKO_LSB +: OFFSET_W]);
		base   = 2 * BEAT_BYTES + off - in_abs;
		one    = take_in && (cmd_op(cur_cmd) == OP_ONE);
		if (one && !cf_format_sel) begin
			// Stamp bytes land only on the incoming beat, so each is written once
			for (int i = 2 * BEAT_BYTES; i < WIN_BYTES; i++) begin
				a = in_abs + i - 2 * BEAT_BYTES;
				if (a >= off && a < off + TOD_BYTES) begin
					vb[i] = cur_ts[(TOD_BYTES - 1 - (a - off)) * 8 +: 8];
				end
			end
			// Checksum was built over a zeroed stamp, so adding the stamp words suffices
			for (int i = 2 * BEAT_BYTES; i < WIN_BYTES; i += 2) begin
				a = in_abs + i - 2 * BEAT_BYTES;
				if (cur_cmd[CK_BIT] && a == cko) begin
					ck = ~oc_add(~{vb[i], vb[i+1]}, ts_words(cur_ts));
					vb[i]   = ck[15:8];
					vb[i+1] = ck[7:0];
				end
			end
		end
		if (one && cf_format_sel && (off + CF_BYTES - 1 >= in_abs) &&
				(off + CF_BYTES - 1 < in_abs + BEAT_BYTES)) begin
			// Whole field is in the window once its last byte arrives
			for (int j = 0; j < CF_BYTES; j++) begin
				old_cf[(CF_BYTES - 1 - j) * 8 +: 8] = vb[base + j];
			end
			new_cf = old_cf + cur_ts[CMD_W-1:0];
			for (int j = 0; j < CF_BYTES; j++) begin
				vb[base + j] = new_cf[(CF_BYTES - 1 - j) * 8 +: 8];
			end
			if (cur_cmd[CK_BIT] && base >= CK_BEFORE_CF) begin
				ck = ~{vb[base - CK_BEFORE_CF], vb[base - CK_BEFORE_CF + 1]};
				for (int w = 0; w < CF_WORDS; w++) begin
					ck = oc_add(ck, ~old_cf[w*16 +: 16]);
					ck = oc_add(ck, new_cf[w*16 +: 16]);
				end
				ck = ~ck;
				vb[base - CK_BEFORE_CF]     = ck[15:8];
				vb[base - CK_BEFORE_CF + 1] = ck[7:0];
			end
		end
		for (int i = 0; i < BEAT_BYTES; i++) begin
			ed1[i*8 +: 8] = vb[i];
			ed0[i*8 +: 8] = vb[i+BEAT_BYTES];
			edi[i*8 +: 8] = vb[i+2*BEAT_BYTES];
		end
	end

	// Window shift; bubbles enter only while a frame tail drains
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wv_r <= '0;
			wl_r <= '0;
			ws_r <= '0;
			wu_r <= '0;
			for (int s = 0; s < 3; s++) begin
				wd_r[s] <= '0;
				wk_r[s] <= '0;
			end
		end else if (shift) begin
			wd_r[2] <= take_in ? ed1 : wd_r[1];
			wd_r[1] <= take_in ? ed0 : wd_r[0];
			wd_r[0] <= edi;
			wk_r[2] <= wk_r[1];
			wk_r[1] <= wk_r[0];
			wk_r[0] <= f_keep;
			wv_r    <= {wv_r[1:0], take_in};
			wl_r    <= {wl_r[1:0], take_in && f_last};
			ws_r    <= {ws_r[1:0], take_in && f_sof};
			wu_r    <= {wu_r[1:0], take_in && f_unr};
		end else if (tx_out_ready) begin
			wv_r[2] <= 1'b0;
		end
	end

	// Frame context: command, stamp, beat count, tail flag
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctx_cmd_r <= '0;
			ts_r      <= '0;
			cnt_r     <= '0;
			tail_r    <= 1'b0;
		end else begin
			if (shift && take_in) begin
				cnt_r <= f_sof ? 13'h0001 : cnt_r + 13'h0001;
				if (f_sof) begin
					ctx_cmd_r <= f_cmd;
					ts_r      <= ts_now;
				end
			end
			if (shift && take_in && f_last) begin
				tail_r <= 1'b1;
			end else if (tail_r && !wv_r[0] && !wv_r[1] && (!wv_r[2] || tx_out_ready)) begin
				tail_r <= 1'b0;
			end
		end
	end

	// Latency setting, loaded by the client, reset to the full path value
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_lat_r <= TX_LAT_RST;
		end else if (tx_lat_wr) begin
			tx_lat_r <= tx_lat_val;
		end
	end

	// Check sequence runs over edited beats as they reach the output slot
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			crc_r <= CRC_INIT;
		end else if (shift && wv_r[1]) begin
			crc_r <= crc_upd(ws_r[1] ? CRC_INIT : crc_r, take_in ? ed1 : wd_r[1], wk_r[1]);
		end
	end

	// Stamp return for one-step and two-step frames; none for no-operation
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_ts_valid    <= 1'b0;
			tx_ts          <= '0;
			tx_ts_tag      <= '0;
			tx_ts_two_step <= 1'b0;
		end else begin
			tx_ts_valid <= 1'b0;
			if (shift && take_in && f_sof && (cmd_op(f_cmd) == OP_ONE || cmd_op(f_cmd) == OP_TWO)) begin
				tx_ts_valid    <= 1'b1;
				tx_ts          <= ts_now;
				tx_ts_two_step <= cmd_op(f_cmd) == OP_TWO;
				tx_ts_tag      <= (cmd_op(f_cmd) == OP_TWO) ? f_cmd[TAG_LSB +: TAG_W] : '0;
			end
		end
	end

	assign tx_out_data     = wd_r[2];
	assign tx_out_keep     = wk_r[2];
	assign tx_out_last     = wl_r[2];
	assign tx_out_underrun = wu_r[2];
	assign tx_out_valid    = wv_r[2];
	assign tx_out_fcs      = ~crc_r;
	assign tx_lat_cur      = tx_lat_r;

	////////////////////////////////////////////////////////////////////////
	// Receive: stamp at start code, out of band and optionally in line

	logic [TS_W-1:0] rx_cap_r;
	logic            rx_first_r;

	// Capture sits at the coding layer edge, ahead of any variable delay
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx_cap_r <= '0;
		end else if (rx_start) begin
			rx_cap_r <= cf_format_sel ? {16'h0000, systime[CMD_W-1:0]} : systime;
		end
	end

	// Preamble beat is replaced by the in-line stamp or dropped
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			m_axis_rx_tdata  <= '0;
			m_axis_rx_tkeep  <= '0;
			m_axis_rx_tlast  <= 1'b0;
			m_axis_rx_tvalid <= 1'b0;
			rx_ts_valid      <= 1'b0;
			rx_ts            <= '0;
			rx_first_r       <= 1'b1;
		end else begin
			m_axis_rx_tvalid <= 1'b0;
			rx_ts_valid      <= 1'b0;
			if (rx_in_valid && rx_in_pre) begin
				m_axis_rx_tvalid <= rx_inline_ts_en;
				m_axis_rx_tkeep  <= '1;
				m_axis_rx_tlast  <= 1'b0;
				m_axis_rx_tdata  <= cf_format_sel ? rx_cap_r[CMD_W-1:0] :
					{rx_cap_r[NS_W +: 32], rx_cap_r[NS_W-1:0]};
			end else if (rx_in_valid) begin
				m_axis_rx_tvalid <= 1'b1;
				m_axis_rx_tdata  <= rx_in_data;
				m_axis_rx_tkeep  <= rx_in_keep;
				m_axis_rx_tlast  <= rx_in_last;
				rx_first_r       <= rx_in_last;
				if (rx_first_r) begin
					rx_ts_valid <= 1'b1;
					rx_ts       <= rx_cap_r;
				end
			end
		end
	end

endmodule // ptp_timestamp_command_path

`default_nettype wire

// >>> testbench/ptp_ts_checker.sv
`timescale 1ns/100ps
`default_nettype none

module ptp_ts_checker
	import ptp_ts_pkg::*;
(
	// Clock and reset
	input wire logic              core_clk,
	input wire logic              rst_n,
	// Configuration
	input wire logic              cf_format_sel,
	input wire logic              rx_inline_ts_en,
	input wire logic              tx_lat_wr,
	input wire logic [LAT_W-1:0]  tx_lat_val,
	input wire logic [LAT_W-1:0]  tx_lat_cur,
	input wire logic [TS_W-1:0]   systime,
	// Transmit stamp return
	input wire logic              tx_ts_valid,
	input wire logic [TS_W-1:0]   tx_ts,
	input wire logic [TAG_W-1:0]  tx_ts_tag,
	input wire logic              tx_ts_two_step,
	// Receive side
	input wire logic              rx_start,
	input wire logic [DATA_W-1:0] rx_in_data,
	input wire logic              rx_in_pre,
	input wire logic              rx_in_valid,
	input wire logic [DATA_W-1:0] m_axis_rx_tdata,
	input wire logic              m_axis_rx_tvalid,
	input wire logic              rx_ts_valid,
	input wire logic [TS_W-1:0]   rx_ts
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Coding-layer beats, split by the preamble mark
	sequence pre_beat_s;
		rx_in_valid && rx_in_pre;
	endsequence
	sequence data_beat_s;
		rx_in_valid && !rx_in_pre;
	endsequence
	sequence start_s;
		rx_start ##1 pre_beat_s;
	endsequence

	//////////////////////////////
	// Latency register
	lat_reset_a: assert property ($rose(rst_n) |-> tx_lat_cur == TX_LAT_RST) else $error("latency reset value");
	lat_load_a: assert property (tx_lat_wr |=> tx_lat_cur == $past(tx_lat_val)) else $error("latency load");

	// Transmit stamp: the bench holds the timer still during a frame
	cf_stamp_a: assert property (tx_ts_valid && cf_format_sel |->
		tx_ts == {16'h0000, systime[63:0] + tx_lat_cur}) else $error("cf stamp sum");
	tag_gate_a: assert property (tx_ts_valid && !tx_ts_two_step |-> tx_ts_tag == 16'h0000) else $error("tag leak");

	//////////////////////////////
	// Receive path
	rx_pass_a: assert property (data_beat_s |=> m_axis_rx_tvalid && m_axis_rx_tdata == $past(rx_in_data))
		else $error("rx data pass");
	pre_drop_a: assert property (pre_beat_s ##0 !rx_inline_ts_en |=> !m_axis_rx_tvalid)
		else $error("preamble not dropped");
	inline_ts_a: assert property (start_s ##0 rx_inline_ts_en |=>
		m_axis_rx_tvalid && m_axis_rx_tdata == 64'($past(systime, 2))) else $error("inline stamp");
	rx_capture_a: assert property (start_s ##0 !cf_format_sel ##1 data_beat_s |=>
		rx_ts_valid && rx_ts == $past(systime, 3)) else $error("rx capture");
	rx_flag_a: assert property (rx_ts_valid |-> m_axis_rx_tvalid) else $error("rx stamp flag");
endmodule // ptp_ts_checker

bind ptp_timestamp_command_path ptp_ts_checker i_ptp_ts_checker (.core_clk, .rst_n, .cf_format_sel,
	.rx_inline_ts_en, .tx_lat_wr, .tx_lat_val, .tx_lat_cur, .systime, .tx_ts_valid, .tx_ts, .tx_ts_tag,
	.tx_ts_two_step, .rx_start, .rx_in_data, .rx_in_pre, .rx_in_valid, .m_axis_rx_tdata,
	.m_axis_rx_tvalid, .rx_ts_valid, .rx_ts);

`default_nettype wire

// >>> testbench/line_sink.sv
`timescale 1ns/100ps
`default_nettype none

module line_sink (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Handshake
	input  wire logic stall_en,
	output var logic  tx_out_ready
);
	// Random back-pressure so the edit window must hold its beats
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			tx_out_ready <= 1'b0;
		else
			tx_out_ready <= !stall_en || $urandom_range(1, 0) == 1;
	end
endmodule // line_sink

`default_nettype wire

// >>> testbench/ptp_timestamp_command_path_tb.sv
`timescale 1ns/100ps
`default_nettype none

module ptp_timestamp_command_path_tb;
	import ptp_ts_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, inband_cmd_en = 1'b0, custom_preamble_en = 1'b0;
	logic cf_format_sel = 1'b0, rx_inline_ts_en = 1'b0, tx_lat_wr = 1'b0, stall_en = 1'b0;
	logic [LAT_W-1:0]   tx_lat_val = '0, tx_lat_cur, lat;
	logic [TS_W-1:0]    systime = '0, tx_ts, rx_ts, st;
	logic [DATA_W-1:0]  s_axis_tx_tdata = '0, tx_out_data, rx_in_data = '0, m_axis_rx_tdata;
	logic [KEEP_W-1:0]  s_axis_tx_tkeep = '0, tx_out_keep, rx_in_keep = '0, m_axis_rx_tkeep;
	logic [TUSER_W-1:0] s_axis_tx_tuser = '0;
	logic s_axis_tx_tlast = 1'b0, s_axis_tx_tvalid = 1'b0, s_axis_tx_tready, tx_out_ready;
	logic tx_out_last, tx_out_underrun, tx_out_valid, tx_ts_valid, tx_ts_two_step;
	logic rx_start = 1'b0, rx_in_last = 1'b0, rx_in_pre = 1'b0, rx_in_valid = 1'b0;
	logic m_axis_rx_tlast, m_axis_rx_tvalid, rx_ts_valid, unr_seen = 1'b0;
	logic [31:0]        tx_out_fcs, fcs_seen = '0;
	logic [TAG_W-1:0]   tx_ts_tag;
	logic [7:0]         frm[$], outq[$];
	int                 bad_count = 0, compares = 0, cyc = 0, n_ts = 0;

	ptp_timestamp_command_path i_ptp_timestamp_command_path (.core_clk, .rst_n, .inband_cmd_en,
		.custom_preamble_en, .cf_format_sel, .rx_inline_ts_en, .tx_lat_wr, .tx_lat_val, .tx_lat_cur,
		.systime, .s_axis_tx_tdata, .s_axis_tx_tkeep, .s_axis_tx_tlast, .s_axis_tx_tuser,
		.s_axis_tx_tvalid, .s_axis_tx_tready, .tx_out_data, .tx_out_keep, .tx_out_last, .tx_out_underrun,
		.tx_out_fcs, .tx_out_valid, .tx_out_ready, .tx_ts_valid, .tx_ts, .tx_ts_tag, .tx_ts_two_step,
		.rx_start, .rx_in_data, .rx_in_keep, .rx_in_last, .rx_in_pre, .rx_in_valid, .m_axis_rx_tdata,
		.m_axis_rx_tkeep, .m_axis_rx_tlast, .m_axis_rx_tvalid, .rx_ts_valid, .rx_ts);
	line_sink i_line_sink (.core_clk, .rst_n, .stall_en, .tx_out_ready);

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	// Line monitor, stamp pulse counter and hang guard; mid-cycle sampling dodges the edge race
	always @(negedge core_clk) begin
		cyc++;
		if (tx_ts_valid)
			n_ts++;
		if (tx_out_valid && tx_out_ready) begin
			for (int l = 0; l < KEEP_W; l++)
				if (tx_out_keep[l])
					outq.push_back(tx_out_data[8*l+:8]);
			if (tx_out_last)
				{fcs_seen, unr_seen} = {tx_out_fcs, tx_out_underrun};
		end
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end

	//////////////////////////////
	task automatic chk(input string nm, input logic [TS_W-1:0] e, input logic [TS_W-1:0] g);
		compares++;
		if (e !== g) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic final_report();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Expected stamp: timer plus latency, nanoseconds wrap into seconds
	function automatic logic [TS_W-1:0] stamp(input logic [TS_W-1:0] t, input logic [LAT_W-1:0] d, input logic cf);
		logic [NS_W:0] ns;
		ns = t[NS_W-1:0] + d;
		if (cf)
			return {16'h0000, t[63:0] + 64'(d)};
		if (ns >= NS_PER_SEC)
			return {t[TS_W-1:NS_W] + 48'h1, ns[NS_W-1:0] - NS_PER_SEC};
		return {t[TS_W-1:NS_W], ns[NS_W-1:0]};
	endfunction

	// Ones complement update: drop old words, add new ones, fold carries
	function automatic logic [15:0] ck_fix(input logic [15:0] c, input logic [TS_W-1:0] o, n);
		logic [31:0] s;
		s = {16'h0000, ~c};
		for (int k = 0; k < TOD_WORDS; k++)
			s += {16'h0000, ~o[16*k+:16]} + {16'h0000, n[16*k+:16]};
		s = s[15:0] + s[31:16];
		s = s[15:0] + s[31:16];
		return ~s[15:0];
	endfunction

	// Expected check sequence over the edited bytes
	function automatic logic [31:0] fcs(input logic [7:0] q[$]);
		logic [31:0] r;
		r = CRC_INIT;
		foreach (q[i])
			for (int b = 0; b < 8; b++)
				r = (r >> 1) ^ (r[0] ^ q[i][b] ? CRC_POLY : '0);
		return ~r;
	endfunction

	// One beat, held until taken; ready is read mid-cycle, where it has settled
	task automatic put(input logic [63:0] d, input logic [127:0] u, input logic l);
		logic rdy;
		s_axis_tx_tdata <= d;
		s_axis_tx_tuser <= u;
		s_axis_tx_tlast <= l;
		s_axis_tx_tkeep <= 8'hFF;
		s_axis_tx_tvalid <= 1'b1;
		do begin
			@(negedge core_clk);
			rdy = s_axis_tx_tready;
			@(posedge core_clk);
		end while (rdy !== 1'b1);
	endtask

	// 24-byte frame; random reserved bits must be ignored
	task automatic tx_case(input logic [1:0] op, input logic cf, input logic inb);
		logic [CMD_W-1:0] cmd;
		logic [127:0]     u;
		logic [63:0]      d, cfv;
		logic [TS_W-1:0]  e;
		logic [TAG_W-1:0] tag;
		logic             ck;
		int               off, cko;
		tag = 16'($urandom);
		off = 2 * $urandom_range(7, 0);
		cko = off >= 12 ? 0 : 22;
		ck = 1'($urandom);
		cmd = {16'(cko), 16'(off), tag, 7'($urandom), ck, 6'($urandom), op};
		u = {inb ? 64'($urandom) : cmd, 63'($urandom), 1'($urandom)};
		systime <= {48'({$urandom, $urandom}), 32'($urandom_range(999999999, 999999800))};
		cf_format_sel <= cf;
		inband_cmd_en <= inb || custom_preamble_en;
		stall_en <= 1'($urandom);
		@(posedge core_clk);
		st = systime;
		frm = {};
		outq = {};
		n_ts = 0;
		for (int i = 0; i < 24; i++)
			frm.push_back(!cf && i >= off && i < off + TOD_BYTES ? 8'h00 : 8'($urandom));
		if (inb)
			put(cmd, u, 1'b0);
		for (int b = 0; b < 3; b++) begin
			for (int l = 0; l < 8; l++)
				d[8*l+:8] = frm[8*b+l];
			put(d, u, b == 2);
		end
		s_axis_tx_tvalid <= 1'b0;
		e = stamp(st, lat, cf);
		if (op == OP_ONE && !cf)
			for (int i = 0; i < TOD_BYTES; i++)
				frm[off+i] = e[TS_W-1-8*i-:8];
		if (op == OP_ONE && !cf && ck)
			{frm[cko], frm[cko+1]} = ck_fix({frm[cko], frm[cko+1]}, '1, e);
		if (op == OP_ONE && cf) begin
			for (int i = 0; i < CF_BYTES; i++)
				cfv[63-8*i-:8] = frm[off+i];
			if (ck && off >= CK_BEFORE_CF)
				{frm[off-10], frm[off-9]} = ck_fix({frm[off-10], frm[off-9]}, {16'hFFFF, cfv},
					{16'h0000, cfv + e[63:0]});
			cfv = cfv + e[63:0];
			for (int i = 0; i < CF_BYTES; i++)
				frm[off+i] = cfv[63-8*i-:8];
		end
		repeat (150)
			if (outq.size() < 24)
				@(posedge core_clk);
		repeat (2) @(posedge core_clk);
		chk("tx_len", 24, outq.size());
		for (int i = 0; i < 24 && outq.size() == 24; i++)
			chk("tx_byte", frm[i], outq[i]);
		chk("tx_fcs", fcs(frm), fcs_seen);
		chk("tx_unr", u[0], unr_seen);
		chk("ts_count", op == OP_ONE || op == OP_TWO, n_ts);
		if (op == OP_ONE || op == OP_TWO) begin
			chk("tx_ts", e, tx_ts);
			chk("tx_tag", op == OP_TWO ? tag : 16'h0000, tx_ts_tag);
			chk("two_step", op == OP_TWO, tx_ts_two_step);
		end
		$display("tx op %0d cf %0d inband %0d done", op, cf, inb);
	endtask

	// Start code, preamble beat, one data beat
	task automatic rx_case(input logic cf, input logic inl);
		logic [63:0] d;
		d = {$urandom, $urandom};
		cf_format_sel <= cf;
		rx_inline_ts_en <= inl;
		rx_start <= 1'b1;
		@(posedge core_clk);
		st = systime;
		rx_start <= 1'b0;
		systime <= systime + 80'h10;
		rx_in_valid <= 1'b1;
		rx_in_pre <= 1'b1;
		rx_in_keep <= 8'hFF;
		rx_in_data <= 64'($urandom);
		@(posedge core_clk);
		rx_in_pre <= 1'b0;
		rx_in_data <= d;
		rx_in_last <= 1'b1;
		@(posedge core_clk);
		rx_in_valid <= 1'b0;
		rx_in_last <= 1'b0;
		@(posedge core_clk);
		chk("rx_data", d, m_axis_rx_tdata);
		if (!cf)
			chk("rx_ts", st, rx_ts);
		$display("rx cf %0d inline %0d done", cf, inl);
	endtask

	//////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'hEF4C1CBB));
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		chk("lat_rst", TX_LAT_RST, tx_lat_cur);
		chk("out_valid", 1'b0, tx_out_valid);
		$display("reset test done");
		lat = TX_LAT_RST;
		for (int c = 0; c < 2; c++)
			for (int o = 0; o < 4; o++)
				for (int i = 0; i < 2; i++)
					tx_case(2'(o), 1'(c), 1'(i));
		lat = 32'($urandom_range(255, 1));
		tx_lat_val <= lat;
		tx_lat_wr <= 1'b1;
		@(posedge core_clk);
		tx_lat_wr <= 1'b0;
		@(posedge core_clk);
		chk("lat_wr", lat, tx_lat_cur);
		tx_case(OP_TWO, 1'b0, 1'b0);
		tx_case(OP_ONE, 1'b1, 1'b1);
		custom_preamble_en <= 1'b1;
		@(posedge core_clk);
		tx_case(OP_TWO, 1'b0, 1'b0);
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 2; i++)
				rx_case(1'(c), 1'(i));
		final_report();
	end
endmodule // ptp_timestamp_command_path_tb

`default_nettype wire
